// file: dv/acb_host_model.sv
// Host model: descriptor memory and stream sink
`timescale 1ns/1ps
`default_nettype none
module acb_host_model (
  // Clock and reset
  input  wire logic               mclk,
  input  wire logic               rst,
  // Scenario knobs
  input  wire logic [2:0]         fetch_wait,
  input  wire logic               stall,
  input  var  acb_pkg::acb_desc_s tbl [4],
  // Descriptor fetch
  input  wire logic               desc_req,
  input  wire logic [31:0]        desc_addr,
  output logic                    desc_valid,
  output acb_pkg::acb_desc_s      desc_in,
  // Stream sink
  output logic                    host_ready
);
  import acb_pkg::*;
  logic [2:0] wait_cnt; // Cycles the fetch has waited
  // One answer pulse per request, after the chosen wait
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      desc_valid <= 1'b0;
      wait_cnt   <= 3'h0;
    end else if (desc_valid) begin
      desc_valid <= 1'b0;
      wait_cnt   <= 3'h0;
    end else if (desc_req && wait_cnt == fetch_wait) begin
      desc_valid <= 1'b1;
    end else if (desc_req) begin
      wait_cnt <= wait_cnt + 3'h1;
    end
  end
  // Unqualified bus flips every cycle so a stale read shows
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      desc_in <= '0;
    end else if (desc_req && !desc_valid && wait_cnt == fetch_wait) begin
      desc_in <= tbl[desc_addr[9:8]];
    end else begin
      desc_in <= acb_desc_s'(~desc_in);
    end
  end
  // Stalling sink toggles ready each cycle
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) host_ready <= 1'b0;
    else host_ready <= stall ? !host_ready : 1'b1;
  end
endmodule
`default_nettype wire

// file: dv/acb_props.sv
// Port checker for the acquisition, bank and DMA block
`timescale 1ns/1ps
`default_nettype none
`include "acb_consts.svh"
module acb_props #(
  parameter int BANK_WORDS = 8
) (
  // Clock and reset
  input wire logic                  mclk,
  input wire logic                  rst,
  // Causes
  input wire logic                  adc_valid,
  input wire logic                  acq_en,
  input wire acb_pkg::acb_chan_e    chan_mode,
  input wire logic                  dma_start,
  input wire logic [31:0]           desc_head,
  input wire logic                  desc_valid,
  input wire logic                  host_ready,
  // Effects
  input wire logic [3:0]            bank_wr,
  input wire logic [3:0][26:0]      bank_addr,
  input wire logic [3:0][31:0]      bank_wdata,
  input wire logic                  sync_ref_out,
  input wire logic                  desc_req,
  input wire logic [31:0]           desc_addr,
  input wire logic [31:0]           host_data,
  input wire logic                  host_valid,
  input wire logic                  host_last,
  input wire logic                  dma_busy
);
  import acb_pkg::*;
  // One domain; reset abandons every check
  default clocking @(posedge mclk); endclocking
  default disable iff (rst);
  // Fetch launched from an idle engine
  sequence s_launch;
    dma_start && !dma_busy;
  endsequence
  // Single-channel write landing in the first bank
  sequence s_first_bank;
    chan_mode == ACB_CH_SINGLE && bank_wr == 4'h1;
  endsequence
  chk_bank_cause: assert property (|bank_wr |-> $past(adc_valid && acq_en))
    else $error("bank write without a taken beat");
  chk_single_onehot: assert property (chan_mode == ACB_CH_SINGLE |-> $onehot0(bank_wr))
    else $error("single mode wrote two banks");
  chk_single_rotate: assert property (s_first_bank ##1 (|bank_wr) |-> bank_wr == 4'h2)
    else $error("single mode rotation broken");
  chk_dual_split: assert property (chan_mode == ACB_CH_DUAL && |bank_wr |->
    bank_wr == 4'h5 || bank_wr == 4'ha)
    else $error("dual mode bank pairing broken");
  chk_dual_width: assert property (chan_mode == ACB_CH_DUAL && bank_wr[2] |->
    bank_wdata[2][31:12] == 20'h0)
    else $error("dual mode word not one sample");
  chk_bank_depth: assert property (bank_wr[0] |-> bank_addr[0] < BANK_WORDS)
    else $error("bank address past its depth");
  chk_fetch_start: assert property (s_launch |=> desc_req && desc_addr == $past(desc_head))
    else $error("fetch not launched at head");
  chk_fetch_hold: assert property (desc_req && !desc_valid |=> desc_req && $stable(desc_addr))
    else $error("fetch request dropped early");
  chk_fetch_end: assert property (desc_req && desc_valid |=> !desc_req)
    else $error("fetch request outlived answer");
  chk_host_hold: assert property (host_valid && !host_ready |=>
    host_valid && $stable(host_data) && $stable(host_last))
    else $error("host word changed while stalled");
  chk_ref_period: assert property ($rose(sync_ref_out) |->
    sync_ref_out [*4] ##1 !sync_ref_out)
    else $error("reference output period wrong");
endmodule
// Checker rides on every copy of the top
bind acb_top acb_props #(.BANK_WORDS(BANK_WORDS)) i_props (.mclk, .rst, .adc_valid, .acq_en,
  .chan_mode, .dma_start, .desc_head, .desc_valid, .host_ready, .bank_wr, .bank_addr,
  .bank_wdata, .sync_ref_out, .desc_req, .desc_addr, .host_data, .host_valid, .host_last,
  .dma_busy);
`default_nettype wire

// file: dv/adc_capture_bank_dma_bench.sv
// Self-checking bench for the acquisition, bank and DMA block
`timescale 1ns/1ps
`default_nettype none
module adc_capture_bank_dma_bench;
  import acb_pkg::*;
  localparam int BW = 8; // Shrunk bank depth keeps fills short
  logic             mclk, rst, adc_valid, src_test, acq_en, cap_arm, trig_pin, sync_gate_pin;
  logic             dma_start, stall, host_valid, host_last, sync_ref_out, cap_done;
  logic             desc_req, desc_valid, host_ready, dma_busy, overrun;
  acb_pair_s        adc_pair;
  acb_chan_e        chan_mode;
  acb_cap_e         cap_mode;
  acb_trig_e        trig_func;
  acb_desc_s        desc_in;
  acb_desc_s        tbl [4];
  logic [2:0]       fetch_wait;
  logic [3:0]       bank_wr;
  logic [3:0][26:0] bank_addr;
  logic [3:0][31:0] bank_wdata;
  logic [31:0]      desc_head, desc_addr, host_data;
  logic [60:0]      wq [$]; // Bank writes: bank, address, data
  logic [32:0]      hq [$]; // Host words: last, data
  int               bad_count, samples_checked, cycles;
  acb_top #(.BANK_WORDS(BW)) i_dut (.mclk, .rst, .adc_pair, .adc_valid, .src_test, .chan_mode,
    .cap_mode, .trig_func, .acq_en, .cap_arm, .trig_pin, .sync_gate_pin, .sync_rst_pin(1'b0),
    .sync_ref_pin(1'b0), .sync_ref_out, .bank_wr, .bank_addr, .bank_wdata, .cap_done,
    .dma_start, .desc_head, .desc_req, .desc_addr, .desc_valid, .desc_in, .host_data,
    .host_valid, .host_last, .host_ready, .dma_busy, .overrun);
  acb_host_model i_host (.mclk, .rst, .fetch_wait, .stall, .tbl, .desc_req, .desc_addr,
    .desc_valid, .desc_in, .host_ready);
  // 40 MHz clock
  initial begin
    mclk = 1'b0;
    forever #12.5 mclk = ~mclk;
  end
  // Log bank writes and taken host words; cut a hang short
  always @(posedge mclk) begin
    for (int b = 0; b < 4; b++) begin
      if (bank_wr[b] === 1'b1) wq.push_back({2'(b), bank_addr[b], bank_wdata[b]});
    end
    if (host_valid === 1'b1 && host_ready === 1'b1) hq.push_back({host_last, host_data});
    cycles++;
    if (cycles == 20000) begin
      bad_count++;
      print_verdict();
    end
  end
  task automatic tick(input int n);
    repeat (n) @(posedge mclk);
  endtask
  task automatic chk(input logic [63:0] got, input logic [63:0] exp);
    samples_checked++;
    if (got !== exp) begin
      bad_count++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic print_verdict();
    if (bad_count == 0 && samples_checked > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  // Reset with a new mode set; pins need two extra edges
  task automatic restart(input acb_chan_e ch, input acb_cap_e cm, input acb_trig_e tf);
    rst <= 1'b1;
    chan_mode <= ch;
    cap_mode <= cm;
    trig_func <= tf;
    tick(5);
    wq.delete();
    hq.delete();
    rst <= 1'b0;
    tick(4);
  endtask
  // Back-to-back beats; sample clock already folded into mclk
  task automatic beats(input int n);
    for (int k = 0; k < n; k++) begin
      @(posedge mclk);
      adc_valid <= 1'b1;
      adc_pair <= acb_pair_s'({12'(k + 'h100), 12'(k + 'h200)});
    end
    @(posedge mclk);
    adc_valid <= 1'b0;
    tick(3);
  endtask
  // Launch the engine, return once the descriptor is in
  task automatic start_dma(input logic [31:0] head);
    desc_head <= head;
    dma_start <= 1'b1;
    @(posedge mclk);
    dma_start <= 1'b0;
    tick(2);
    for (int i = 0; i < 50 && !(dma_busy === 1'b1 && desc_req === 1'b0); i++) @(posedge mclk);
  endtask
  // Bounded wait for host words, then room for extras
  task automatic wait_hq(input int n);
    for (int i = 0; i < 400 && hq.size() < n; i++) @(posedge mclk);
    tick(4);
  endtask
  // Packed single-mode word from s0 and s1
  function automatic logic [31:0] pk(input int a);
    return {4'h0, 12'(a + 1), 4'h0, 12'(a)};
  endfunction
  initial begin
    int n;
    rst = 1'b1;
    adc_valid = 1'b0;
    adc_pair = '0;
    src_test = 1'b1;
    acq_en = 1'b1;
    cap_arm = 1'b0;
    trig_pin = 1'b0;
    sync_gate_pin = 1'b0;
    dma_start = 1'b0;
    desc_head = 32'h0;
    stall = 1'b0;
    fetch_wait = 3'h0;
    foreach (tbl[i]) tbl[i] = '0;
    // Test ramp, single channel: rotation over all banks
    restart(ACB_CH_SINGLE, ACB_CAP_FIFO, ACB_TRIG_GATE);
    beats(8);
    chk(64'(wq.size()), 64'd8);
    for (int k = 0; k < 8; k++) chk(64'(wq[k]), {3'h0, 2'(k % 4), 27'(k / 4), pk(2 * k)});
    chk(64'(overrun), 64'd0);
    // Converter, dual channel: split of samples over bank pairs
    src_test <= 1'b0;
    restart(ACB_CH_DUAL, ACB_CAP_FIFO, ACB_TRIG_GATE);
    beats(6);
    for (int k = 0; k < 6; k++) begin
      chk(64'(wq[2 * k]), {3'h0, 2'(k % 2), 27'(k / 2), 32'(k + 'h200)});
      chk(64'(wq[2 * k + 1]), {3'h0, 2'(k % 2 + 2), 27'(k / 2), 32'(k + 'h100)});
    end
    // Wrapping buffer against capture that stops at full
    src_test <= 1'b1;
    for (int m = 0; m < 2; m++) begin
      restart(ACB_CH_SINGLE, m ? ACB_CAP_TRANS : ACB_CAP_FIFO, ACB_TRIG_GATE);
      beats(40);
      chk(64'(wq.size()), m ? 64'(4 * BW) : 64'd40);
      chk(64'(cap_done), 64'(m));
      chk(64'(wq[wq.size() - 1] >> 32), {35'h0, 2'd3, 27'(m ? BW - 1 : 9 % BW)});
      chk(64'(overrun), 64'd1);
    end
    // Arming clears the stop and restarts the walk at bank 0, slot 0
    cap_arm <= 1'b1;
    tick(1);
    cap_arm <= 1'b0;
    tick(2);
    chk(64'(cap_done), 64'd0);
    chk(64'(overrun), 64'd0);
    beats(1);
    chk(64'(wq[wq.size() - 1] >> 32), 64'd0);
    // Fixed-length chain with metadata on the first link, slow host
    restart(ACB_CH_SINGLE, ACB_CAP_FIFO, ACB_TRIG_GATE);
    tbl[1] <= '{32'h200, 24'd3, 1'b0, 1'b1, 1'b0};
    tbl[2] <= '{32'h0, 24'd2, 1'b0, 1'b0, 1'b1};
    fetch_wait <= 3'h4;
    stall <= 1'b1;
    beats(5);
    start_dma(32'h100);
    wait_hq(7);
    chk(64'(hq.size()), 64'd7);
    for (int k = 0; k < 3; k++) chk(64'(hq[k]), 64'(pk(2 * k)));
    chk(64'(hq[3]), 64'd5);
    chk(64'(hq[4]), {31'h0, 1'b1, 32'd3});
    for (int k = 3; k < 5; k++) chk(64'(hq[k + 2]), {31'h0, 1'(k == 4), pk(2 * k)});
    chk(64'(dma_busy), 64'd0);
    // Gate-driven link: pin gates only in gate function, sync gate always
    for (int f = 0; f < 3; f++) begin
      restart(ACB_CH_SINGLE, ACB_CAP_FIFO, acb_trig_e'(3'(1 << f)));
      tbl[1] <= '{32'h0, 24'd0, 1'b1, 1'b1, 1'b1};
      fetch_wait <= 3'h0;
      stall <= f[0];
      start_dma(32'h100);
      adc_valid <= 1'b1;
      trig_pin <= 1'b1;
      sync_gate_pin <= 1'b1;
      tick(3);
      sync_gate_pin <= 1'b0;
      tick(3);
      trig_pin <= 1'b0;
      tick(4);
      adc_valid <= 1'b0;
      n = (f == 0) ? 6 : 3;
      wait_hq(n + 2);
      chk(64'(hq.size()), 64'(n + 2));
      // Time word: beats before the gate, or realigned by the PPS or sync edge
      chk(64'(hq[n]), 64'(f == 0 ? 3 : f == 1 ? 'h10000 : 0));
      chk(64'(hq[n + 1]), {31'h0, 1'b1, 32'(n)});
      chk(64'(dma_busy), 64'd0);
    end
    print_verdict();
  end
endmodule
`default_nettype wire

// file: hdl/acb_fifo.sv
// Small synchronous FIFO with valid/ready on both sides
`timescale 1ns/1ps
`default_nettype none
module acb_fifo #(
  parameter int WIDTH = 33,
  parameter int DEPTH = 16
) (
  // Clock and reset
  input  wire logic             mclk,
  input  wire logic             rst,
  // Fill side
  input  wire logic             in_valid,
  output logic                  in_ready,
  input  wire logic [WIDTH-1:0] in_data,
  // Drain side
  output logic                  out_valid,
  input  wire logic             out_ready,
  output logic      [WIDTH-1:0] out_data
);
  localparam int AW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem [DEPTH];  // Storage array
  logic [AW-1:0]    wr_ptr;       // Next write slot
  logic [AW-1:0]    rd_ptr;       // Next read slot
  logic [AW:0]      count;        // Words held
  logic             push;
  logic             pop;
  logic [AW-1:0]    rd_next;      // Read slot after this edge

  assign in_ready  = (count != (AW+1)'(DEPTH));
  assign out_valid = (count != '0);
  assign push      = in_valid && in_ready;
  assign pop       = out_valid && out_ready;
  assign rd_next   = pop ? rd_ptr + AW'(1) : rd_ptr;

  // Read register looks one pop ahead; a write into that slot bypasses the array
  always_ff @(posedge mclk) begin
    if (push && (wr_ptr == rd_next)) begin
      out_data <= in_data;
    end else begin
      out_data <= mem[rd_next];
    end
  end

  // Storage write, no reset needed on data
  always_ff @(posedge mclk) begin
    if (push) begin
      mem[wr_ptr] <= in_data;
    end
  end

  // Pointers and occupancy
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
      count  <= '0;
    end else begin
      if (push) begin
        wr_ptr <= wr_ptr + AW'(1);
      end
      if (pop) begin
        rd_ptr <= rd_ptr + AW'(1);
      end
      count <= count + (AW+1)'(push) - (AW+1)'(pop);
    end
  end
endmodule
`default_nettype wire

// file: hdl/acb_top.sv
// Sample acquisition, four-bank capture and linked-list DMA to host
// Notes on behaviour
// - Sample source: converter or test pattern
// - Banks act as FIFO or transient capture
// - Single channel rotates over all four banks
// - Dual: ch1 to banks 1-2, ch2 3-4
// - Capture keeps full rate; a beat met by a full FIFO is dropped and sets overrun
// - Linked descriptor DMA moves data to host
// - Gate mode length equals gated data amount
// - Optional metadata: sample timestamp and length
// - Timing pin acts as gate, PPS or sync
// - Sync bus: gate, reset, reference out; reference in is synchronised but unused
// - Each bank holds a fixed depth
`timescale 1ns/1ps
`default_nettype none
`include "acb_consts.svh"
module acb_top #(
  parameter int BANK_WORDS = `ACB_BANK_WORDS
) (
  // Clock and reset
  input  wire logic                            mclk,
  input  wire logic                            rst,
  // Converter sample stream, already on mclk
  input  wire acb_pkg::acb_pair_s              adc_pair,
  input  wire logic                            adc_valid,
  // Configuration
  input  wire logic                            src_test,
  input  wire acb_pkg::acb_chan_e              chan_mode,
  input  wire acb_pkg::acb_cap_e               cap_mode,
  input  wire acb_pkg::acb_trig_e              trig_func,
  input  wire logic                            acq_en,
  input  wire logic                            cap_arm,
  // Front panel and sync bus pins
  input  wire logic                            trig_pin,
  input  wire logic                            sync_gate_pin,
  input  wire logic                            sync_rst_pin,
  input  wire logic                            sync_ref_pin,
  output logic                                 sync_ref_out,
  // Memory bank write ports
  output logic [`ACB_BANKS-1:0]                bank_wr,
  output logic [`ACB_BANKS-1:0][`ACB_BANK_AW-1:0] bank_addr,
  output logic [`ACB_BANKS-1:0][`ACB_WORD_W-1:0]  bank_wdata,
  output logic                                 cap_done,
  // Descriptor fetch
  input  wire logic                            dma_start,
  input  wire logic [`ACB_DADDR_W-1:0]         desc_head,
  output logic                                 desc_req,
  output logic [`ACB_DADDR_W-1:0]              desc_addr,
  input  wire logic                            desc_valid,
  input  wire acb_pkg::acb_desc_s              desc_in,
  // Host stream toward the PCIe core
  output logic [`ACB_WORD_W-1:0]               host_data,
  output logic                                 host_valid,
  output logic                                 host_last,
  input  wire logic                            host_ready,
  // Status
  output logic                                 dma_busy,
  output logic                                 overrun
);
  import acb_pkg::*;

  // Bank choice for a beat; one bit per bank
  function automatic logic [`ACB_BANKS-1:0] bank_pick(acb_chan_e m, logic [1:0] r);
    logic [`ACB_BANKS-1:0] b;
    b = '0;
    if (m == ACB_CH_DUAL) begin
      b[{1'b0, r[0]}] = 1'b1;
      b[{1'b1, r[0]}] = 1'b1;
    end else begin
      b[r] = 1'b1;
    end
    return b;
  endfunction

  // Pin synchronisers, two flops per line
  logic [3:0] pin_raw;
  logic [3:0] pin_s1;
  logic [3:0] pin_s2;
  assign pin_raw = {sync_ref_pin, sync_rst_pin, sync_gate_pin, trig_pin};

  genvar gi;
  generate
    for (gi = 0; gi < 4; gi++) begin : g_sync
      always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
          pin_s1[gi] <= 1'b0;
          pin_s2[gi] <= 1'b0;
        end else begin
          pin_s1[gi] <= pin_raw[gi];
          pin_s2[gi] <= pin_s1[gi];
        end
      end
    end
  endgenerate

  logic trig_d;      // Previous synced trigger level
  logic gate;        // Combined acquisition gate
  logic gate_d;      // Gate one cycle back
  logic trig_rise;
  logic time_clr;    // Clears the sample clock
  assign trig_rise = pin_s2[0] && !trig_d;
  // Gate from the panel pin when so configured, or from the sync bus
  assign gate      = ((trig_func == ACB_TRIG_GATE) && pin_s2[0]) || pin_s2[1];
  // Sync edge or sync bus reset realigns time
  assign time_clr  = ((trig_func == ACB_TRIG_SYNC) && trig_rise) || pin_s2[2];

  // Edge history
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      trig_d <= 1'b0;
      gate_d <= 1'b0;
    end else begin
      trig_d <= pin_s2[0];
      gate_d <= gate;
    end
  end

  // Outgoing reference: divided mclk, forced low by sync bus reset
  logic [3:0] ref_cnt;
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      ref_cnt      <= '0;
      sync_ref_out <= 1'b0;
    end else if (pin_s2[2]) begin
      ref_cnt      <= '0;
      sync_ref_out <= 1'b0;
    end else if (ref_cnt == 4'(`ACB_REF_DIV - 1)) begin
      ref_cnt      <= '0;
      sync_ref_out <= !sync_ref_out;
    end else begin
      ref_cnt <= ref_cnt + 4'h1;
    end
  end

  // Sample-accurate time: beat count below, PPS seconds above
  logic [15:0] ts_sec;
  logic [15:0] ts_beat;
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      ts_sec  <= '0;
      ts_beat <= '0;
    end else if (time_clr) begin
      ts_sec  <= '0;
      ts_beat <= '0;
    end else if ((trig_func == ACB_TRIG_PPS) && trig_rise) begin
      ts_sec  <= ts_sec + 16'h1;
      ts_beat <= '0;
    end else if (adc_valid) begin
      ts_beat <= ts_beat + 16'h1;
    end
  end

  // Test pattern: even ramp on lane 0, the next odd value on lane 1
  logic [`ACB_SMP_W-1:0] ramp;
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      ramp <= '0;
    end else if (adc_valid) begin
      ramp <= ramp + `ACB_SMP_W'(2);
    end
  end

  acb_pair_s pair;
  // Source select
  assign pair = src_test ? '{s1: ramp + `ACB_SMP_W'(1), s0: ramp} : adc_pair;

  // Beats taken only while enabled; in gate mode only inside the gate
  logic dma_gate_mode;
  logic take;
  assign take = adc_valid && acq_en && (!dma_gate_mode || gate);

  // Bank writes: rotation, per-bank address, transient stop
  logic [1:0]                        rot;
  logic [`ACB_BANKS-1:0][`ACB_BANK_AW-1:0] waddr;
  logic [`ACB_BANKS-1:0]             bfull;
  logic [`ACB_BANKS-1:0]             sel;
  assign sel = bank_pick(chan_mode, rot);

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      rot <= '0;
    end else if (cap_arm) begin
      rot <= '0;
    end else if (take) begin
      rot <= rot + 2'h1;
    end
  end

  generate
    for (gi = 0; gi < `ACB_BANKS; gi++) begin : g_bank
      // Address walk and write strobe for one bank
      always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
          waddr[gi]      <= '0;
          bfull[gi]      <= 1'b0;
          bank_wr[gi]    <= 1'b0;
          bank_addr[gi]  <= '0;
          bank_wdata[gi] <= '0;
        end else begin
          bank_wr[gi] <= 1'b0;
          if (cap_arm) begin
            waddr[gi] <= '0;
            bfull[gi] <= 1'b0;
          end else if (take && sel[gi] && !bfull[gi]) begin
            bank_wr[gi]   <= 1'b1;
            bank_addr[gi] <= waddr[gi];
            if (chan_mode == ACB_CH_DUAL) begin
              // Lower banks hold lane 0, upper banks lane 1
              bank_wdata[gi] <= (gi < 2) ? `ACB_WORD_W'(pair.s0) : `ACB_WORD_W'(pair.s1);
            end else begin
              bank_wdata[gi] <= {4'h0, pair.s1, 4'h0, pair.s0};
            end
            if (waddr[gi] == `ACB_BANK_AW'(BANK_WORDS - 1)) begin
              waddr[gi] <= '0;
              // Transient capture keeps the snapshot; FIFO mode wraps
              bfull[gi] <= (cap_mode == ACB_CAP_TRANS);
            end else begin
              waddr[gi] <= waddr[gi] + `ACB_BANK_AW'(1);
            end
          end
        end
      end
    end
  endgenerate

  // Snapshot complete once any bank stops
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      cap_done <= 1'b0;
    end else begin
      cap_done <= |bfull;
    end
  end

  // Stream into the FIFO; an end-of-gate marker follows the gate's last beat
  acb_fword_s fin;
  acb_fword_s fout;
  logic       fin_valid;
  logic       fin_ready;
  logic       fout_valid;
  logic       fout_ready;
  logic       mark_pend;
  assign fin_valid = take || mark_pend;
  assign fin.eog   = !take;
  assign fin.data  = {4'h0, pair.s1, 4'h0, pair.s0};

  // Marker request on gate fall; cleared when accepted, set wins
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      mark_pend <= 1'b0;
    end else if (dma_gate_mode && gate_d && !gate) begin
      mark_pend <= 1'b1;
    end else if (!take && fin_ready) begin
      mark_pend <= 1'b0;
    end
  end

  // Sticky overflow: beat arrived with the FIFO full; a loss during arm still counts
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      overrun <= 1'b0;
    end else if (take && !fin_ready) begin
      overrun <= 1'b1;
    end else if (cap_arm) begin
      overrun <= 1'b0;
    end
  end

  acb_fifo #(
    .WIDTH ($bits(acb_fword_s)),
    .DEPTH (`ACB_FIFO_DEPTH)
  ) u_fifo (
    .mclk      (mclk),
    .rst       (rst),
    .in_valid  (fin_valid),
    .in_ready  (fin_ready),
    .in_data   (fin),
    .out_valid (fout_valid),
    .out_ready (fout_ready),
    .out_data  (fout)
  );

  // DMA engine over a linked descriptor list
  acb_dma_e              st;
  acb_desc_s             desc;
  logic [`ACB_LEN_W-1:0] moved;
  logic [`ACB_TS_W-1:0]  ts_lat;
  logic                  ts_armed;
  logic                  out_free;
  logic                  fixed_end;
  assign out_free      = !host_valid || host_ready;
  assign dma_gate_mode = desc.gate_mode && (st == ACB_D_MOVE);
  // Pop in MOVE while output free; markers are popped and swallowed
  assign fout_ready    = (st == ACB_D_MOVE) && out_free;
  assign fixed_end     = !desc.gate_mode && (moved == desc.length - `ACB_LEN_W'(1));

  // Descriptor walk and data move
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      st         <= ACB_D_IDLE;
      desc       <= '0;
      desc_req   <= 1'b0;
      desc_addr  <= '0;
      moved      <= '0;
      ts_lat     <= '0;
      ts_armed   <= 1'b0;
      host_data  <= '0;
      host_valid <= 1'b0;
      host_last  <= 1'b0;
      dma_busy   <= 1'b0;
    end else begin
      if (host_ready) begin
        host_valid <= 1'b0;
        host_last  <= 1'b0;
      end
      unique case (st)
        ACB_D_IDLE: begin
          dma_busy <= 1'b0;
          if (dma_start) begin
            desc_addr <= desc_head;
            desc_req  <= 1'b1;
            dma_busy  <= 1'b1;
            st        <= ACB_D_FETCH;
          end
        end
        ACB_D_FETCH: begin
          if (desc_valid) begin
            desc     <= desc_in;
            desc_req <= 1'b0;
            moved    <= '0;
            ts_armed <= 1'b1;
            st       <= ACB_D_MOVE;
          end
        end
        ACB_D_MOVE: begin
          if (fout_valid && out_free) begin
            if (fout.eog) begin
              // Gate end closes this link at the amount moved
              if (desc.gate_mode) begin
                st <= desc.meta_en ? ACB_D_TS : ACB_D_IDLE;
              end
            end else begin
              host_data  <= fout.data;
              host_valid <= 1'b1;
              moved      <= moved + `ACB_LEN_W'(1);
              if (ts_armed) begin
                // Time when the first word of this transfer leaves the FIFO
                ts_lat   <= {ts_sec, ts_beat};
                ts_armed <= 1'b0;
              end
              if (fixed_end) begin
                host_last <= !desc.meta_en;
                st        <= desc.meta_en ? ACB_D_TS : ACB_D_IDLE;
              end
            end
          end
        end
        ACB_D_TS: begin
          if (out_free) begin
            host_data  <= ts_lat;
            host_valid <= 1'b1;
            st         <= ACB_D_LEN;
          end
        end
        ACB_D_LEN: begin
          if (out_free) begin
            host_data  <= `ACB_WORD_W'(moved);
            host_valid <= 1'b1;
            host_last  <= 1'b1;
            st         <= ACB_D_IDLE;
          end
        end
      endcase
      // Follow the link unless this was the last one
      if ((st != ACB_D_IDLE) && (st != ACB_D_FETCH) && !desc.last) begin
        if (((st == ACB_D_LEN) && out_free) ||
            ((st == ACB_D_MOVE) && !desc.meta_en && fout_valid && out_free &&
             (desc.gate_mode ? fout.eog : (!fout.eog && fixed_end)))) begin
          desc_addr <= desc.next_addr;
          desc_req  <= 1'b1;
          st        <= ACB_D_FETCH;
        end
      end
    end
  end
endmodule
`default_nettype wire

// file: include/acb_consts.svh
// Constants for the acquisition, capture bank and DMA block
`ifndef ACB_CONSTS_SVH
`define ACB_CONSTS_SVH

`define ACB_SMP_W      12
`define ACB_WORD_W     32
`define ACB_BANKS      4
`define ACB_BANK_AW    27
`define ACB_BANK_WORDS 134217728
`define ACB_FIFO_DEPTH 16
`define ACB_LEN_W      24
`define ACB_DADDR_W    32
`define ACB_TS_W       32
`define ACB_REF_DIV    4

`endif

// file: include/acb_pkg.sv
// Types shared by the acquisition, capture bank and DMA block
`include "acb_consts.svh"
package acb_pkg;
  typedef enum logic [2:0] {
    ACB_TRIG_GATE = 3'b001,
    ACB_TRIG_PPS  = 3'b010,
    ACB_TRIG_SYNC = 3'b100
  } acb_trig_e;

  typedef enum logic [1:0] {
    ACB_CH_SINGLE = 2'b01,
    ACB_CH_DUAL   = 2'b10
  } acb_chan_e;

  typedef enum logic [1:0] {
    ACB_CAP_FIFO  = 2'b01,
    ACB_CAP_TRANS = 2'b10
  } acb_cap_e;

  typedef enum logic [4:0] {
    ACB_D_IDLE  = 5'b00001,
    ACB_D_FETCH = 5'b00010,
    ACB_D_MOVE  = 5'b00100,
    ACB_D_TS    = 5'b01000,
    ACB_D_LEN   = 5'b10000
  } acb_dma_e;

  // One converter beat: two 12-bit samples
  typedef struct packed {
    logic [`ACB_SMP_W-1:0] s1;
    logic [`ACB_SMP_W-1:0] s0;
  } acb_pair_s;

  // Link descriptor returned by the host
  typedef struct packed {
    logic [`ACB_DADDR_W-1:0] next_addr;
    logic [`ACB_LEN_W-1:0]   length;
    logic                    gate_mode;
    logic                    meta_en;
    logic                    last;
  } acb_desc_s;

  // Buffered word: end-of-gate marker or sample data
  typedef struct packed {
    logic                   eog;
    logic [`ACB_WORD_W-1:0] data;
  } acb_fword_s;
endpackage
